// ### sbpr_cfg.svh
// Constants of the serial bus PHY base register bank
`ifndef SBPR_CFG_SVH
`define SBPR_CFG_SVH
// ==========================================================
// Register indices (byte address is four times the index)
`define SBPR_IDX_NODE 4'h0
`define SBPR_IDX_GAP 4'h1
`define SBPR_IDX_EXT 4'h2
`define SBPR_IDX_SPEED 4'h3
`define SBPR_IDX_PAGE 4'h7
`define SBPR_IDX_PAGED_LO 4'h8
`define SBPR_NUM_REGS 16
// ==========================================================
// Field positions
`define SBPR_NODE_ID_LSB 2
`define SBPR_ROOT_BIT 1
`define SBPR_PWR_BIT 0
`define SBPR_HOLDOFF_BIT 7
`define SBPR_LRR_BIT 6
`define SBPR_PAGE_LSB 5
// ==========================================================
// Reset and fixed values
`define SBPR_GAP_RESET 6'h3f
`define SBPR_EXT_VALUE 3'h7
`define SBPR_NUM_PORTS 4'h4
`define SBPR_SPEED_VALUE 3'h2
`define SBPR_DELAY_VALUE 4'h0
`define SBPR_RSVD_PAGE_LO 3'h2
`define SBPR_RSVD_PAGE_HI 3'h6
// ==========================================================
// Timing
`define SBPR_LONG_RESET_US 166
`define SBPR_CLK_MHZ 200
`define SBPR_LONG_RESET_CYCLES (`SBPR_LONG_RESET_US * `SBPR_CLK_MHZ)
`endif

// ### sbpr_pkg.sv
// Types shared by the serial bus PHY base register bank
`default_nettype none
package sbpr_pkg;
  // ========================================================
  // Long bus-reset sequencer states, one-hot
  typedef enum logic [2:0] {
    SBPR_LR_IDLE = 3'h1,
    SBPR_LR_WAIT = 3'h2,
    SBPR_LR_RUN = 3'h4
  } sbpr_lrst_state_type;
endpackage : sbpr_pkg
`default_nettype wire

// ### sbpr_regs.sv
// Base register bank of a four-port cable serial bus PHY, APB slave
// Functional notes
// - Sixteen registers; addresses 0 to 7 are fixed-layout base registers.
// - Addresses 8h-Fh are paged; page chosen by page selector in register 7.
// - Base field meaning does not depend on the selected page.
// - Reserved registers and reserved bits read as zero.
// - All paged registers on pages two to six read as zero.
// - Node identifier is loaded at self-ID; invalid from bus-reset until then.
// - Root flag cleared by bus-reset, set when node becomes root.
// - Cable power status bit follows the cable power sense input.
// - Root holdoff asks for root after bus-reset; hardware reset clears it.
// - Writing one to long reset request starts a 166 us bus-reset.
// - A receive or transmit under way finishes before that bus-reset.
// - Long reset request is cleared by hardware reset and any bus-reset; here a write of one in the same cycle as a bus-reset sets it.
// - Gap value sets fair gap, arbitration reset gap and arbitration delay.
// - Gap value updates on register write or configuration packet.
// - Gap loads 3Fh at hardware reset and after two bare bus-resets.
// - Extended-set field always reads 111b.
// - Port count field always reads four.
// - Register 3 holds speed 010b, a reserved bit, delay 0000b.
// - Register 7 holds page selector, a reserved bit, port selector.
// - Speed capability reads 010b, the 400 Mbit/s class.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "sbpr_cfg.svh"

module sbpr_regs #(
  parameter int LONG_RESET_CYCLES = `SBPR_LONG_RESET_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PHY core side
  input wire logic bus_reset_in,
  input wire logic self_id_done,
  input wire logic [5:0] self_id_node,
  input wire logic root_won,
  input wire logic cable_power_sense,
  input wire logic config_gap_load,
  input wire logic [5:0] config_gap_value,
  input wire logic link_op_busy,
  output logic node_id_valid,
  output logic root_holdoff,
  output logic [5:0] gap_count,
  output logic long_reset_active,
  output logic [2:0] page_select,
  output logic [3:0] port_select
);

  // ========================================================
  // APB decode
  // pready is tied high: every access completes in its first cycle
  wire logic setup_phase = psel & ~penable;
  wire logic access_phase = psel & penable;
  wire logic [3:0] reg_idx = paddr[5:2];
  wire logic addr_mapped = (paddr[31:6] == 26'h0) & (paddr[1:0] == 2'h0);
  wire logic wr_ok = access_phase & pwrite & addr_mapped & pstrb[0];
  // Only the two writable registers take data; the rest drop it
  wire logic wr_gap = wr_ok & (reg_idx == `SBPR_IDX_GAP);
  wire logic wr_page = wr_ok & (reg_idx == `SBPR_IDX_PAGE);

  // ========================================================
  // Register state
  logic [5:0] node_id_reg;
  logic node_valid_reg;
  logic root_reg;
  logic holdoff_reg;
  logic lrr_reg;
  logic [5:0] gap_reg;
  logic gap_touched_reg;
  logic reset_seen_reg;
  logic [2:0] page_reg;
  logic [3:0] port_reg;
  logic [31:0] rdata_reg;
  sbpr_pkg::sbpr_lrst_state_type lr_state_reg;
  sbpr_pkg::sbpr_lrst_state_type lr_state_next;
  logic [15:0] lr_cnt_reg;

  // ========================================================
  // Long bus-reset sequencer
  wire logic lr_start = (lr_state_next == sbpr_pkg::SBPR_LR_RUN) &
    (lr_state_reg != sbpr_pkg::SBPR_LR_RUN);
  // Last cycle of the run; the counter starts at zero on entry
  wire logic lr_done = (lr_state_reg == sbpr_pkg::SBPR_LR_RUN) &
    (lr_cnt_reg == 16'(LONG_RESET_CYCLES - 1));
  // Our own long reset counts as a bus-reset for every field
  wire logic bus_reset_evt = bus_reset_in | lr_start;
  wire logic lrr_set = wr_gap & pwdata[`SBPR_LRR_BIT];

  // Next state: a pending request waits for link traffic to end
  always_comb begin
    case (lr_state_reg)
      sbpr_pkg::SBPR_LR_IDLE: begin
        if (lrr_reg & link_op_busy) begin
          lr_state_next = sbpr_pkg::SBPR_LR_WAIT;
        end else if (lrr_reg) begin
          lr_state_next = sbpr_pkg::SBPR_LR_RUN;
        end else begin
          lr_state_next = sbpr_pkg::SBPR_LR_IDLE;
        end
      end
      sbpr_pkg::SBPR_LR_WAIT: begin
        // A bus-reset has already withdrawn the request: give up waiting
        if (!lrr_reg) begin
          lr_state_next = sbpr_pkg::SBPR_LR_IDLE;
        end else if (!link_op_busy) begin
          lr_state_next = sbpr_pkg::SBPR_LR_RUN;
        end else begin
          lr_state_next = sbpr_pkg::SBPR_LR_WAIT;
        end
      end
      sbpr_pkg::SBPR_LR_RUN: begin
        if (lr_done) begin
          lr_state_next = sbpr_pkg::SBPR_LR_IDLE;
        end else begin
          lr_state_next = sbpr_pkg::SBPR_LR_RUN;
        end
      end
      default: begin
        lr_state_next = sbpr_pkg::SBPR_LR_IDLE;
      end
    endcase
  end

  // State and duration counter
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lr_state_reg <= sbpr_pkg::SBPR_LR_IDLE;
      lr_cnt_reg <= 16'h0000;
    end else begin
      lr_state_reg <= lr_state_next;
      if (lr_state_reg == sbpr_pkg::SBPR_LR_RUN) begin
        lr_cnt_reg <= lr_cnt_reg + 16'h0001;
      end else begin
        lr_cnt_reg <= 16'h0000;
      end
    end
  end

  // ========================================================
  // Identity, root and reset request
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      node_id_reg <= 6'h00;
      node_valid_reg <= 1'b0;
      root_reg <= 1'b0;
      lrr_reg <= 1'b0;
    end else begin
      if (self_id_done) begin
        node_id_reg <= self_id_node;
        node_valid_reg <= 1'b1;
      end else if (bus_reset_evt) begin
        node_valid_reg <= 1'b0;
      end
      // Set wins, since tree-ID always follows its own reset
      if (root_won) begin
        root_reg <= 1'b1;
      end else if (bus_reset_evt) begin
        root_reg <= 1'b0;
      end
      // A fresh write wins over a same-cycle bus-reset
      if (lrr_set) begin
        lrr_reg <= 1'b1;
      end else if (bus_reset_evt) begin
        lrr_reg <= 1'b0;
      end
    end
  end

  // ========================================================
  // Gap value and the two-reset reload tracker
  wire logic gap_update = wr_gap | config_gap_load;
  wire logic gap_reload = bus_reset_evt & reset_seen_reg &
    ~gap_touched_reg & ~gap_update;

  // Hold-off is untouched by bus-reset
  // A write or load in the same cycle as a bus-reset counts as an update
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      holdoff_reg <= 1'b0;
      gap_reg <= `SBPR_GAP_RESET;
      gap_touched_reg <= 1'b0;
      reset_seen_reg <= 1'b0;
    end else begin
      if (wr_gap) begin
        holdoff_reg <= pwdata[`SBPR_HOLDOFF_BIT];
        gap_reg <= pwdata[5:0];
      end else if (config_gap_load) begin
        gap_reg <= config_gap_value;
      end else if (gap_reload) begin
        gap_reg <= `SBPR_GAP_RESET;
      end
      if (bus_reset_evt) begin
        reset_seen_reg <= 1'b1;
        gap_touched_reg <= gap_update;
      end else if (gap_update) begin
        gap_touched_reg <= 1'b1;
      end
    end
  end

  // ========================================================
  // Page and port selectors
  // A new selection shows from the next read setup onwards
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      page_reg <= 3'h0;
      port_reg <= 4'h0;
    end else if (wr_page) begin
      page_reg <= pwdata[7:`SBPR_PAGE_LSB];
      port_reg <= pwdata[3:0];
    end
  end

  // ========================================================
  // Read views; base fields ignore the page entirely
  wire logic [7:0] rd_node = {node_id_reg, root_reg, cable_power_sense};
  wire logic [7:0] rd_gap = {holdoff_reg, lrr_reg, gap_reg};
  wire logic [7:0] rd_ext = {`SBPR_EXT_VALUE, 1'b0, `SBPR_NUM_PORTS};
  wire logic [7:0] rd_speed = {`SBPR_SPEED_VALUE, 1'b0, `SBPR_DELAY_VALUE};
  wire logic [7:0] rd_page = {page_reg, 1'b0, port_reg};
  wire logic page_rsvd = (page_reg >= `SBPR_RSVD_PAGE_LO) &
    (page_reg <= `SBPR_RSVD_PAGE_HI);
  // Port status pages are not held here, so every paged word reads zero
  // Pages two to six must stay zero even once port pages are added
  wire logic [7:0] rd_paged = page_rsvd ? 8'h00 : 8'h00;
  logic [7:0] rd_mux;

  // Register select; unlisted base words are reserved
  always_comb begin
    case (reg_idx)
      `SBPR_IDX_NODE: rd_mux = rd_node;
      `SBPR_IDX_GAP: rd_mux = rd_gap;
      `SBPR_IDX_EXT: rd_mux = rd_ext;
      `SBPR_IDX_SPEED: rd_mux = rd_speed;
      `SBPR_IDX_PAGE: rd_mux = rd_page;
      default: begin
        if (reg_idx >= `SBPR_IDX_PAGED_LO) begin
          rd_mux = rd_paged;
        end else begin
          rd_mux = 8'h00;
        end
      end
    endcase
  end

  // Read data is caught in the setup cycle so it leaves a flop
  // Trade-off: live inputs such as cable power are seen as they stood
  // at the setup edge, one cycle before the access completes
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (setup_phase & ~pwrite) begin
      rdata_reg <= addr_mapped ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  // ========================================================
  // Outputs
  // Handshake outputs are combinational; data outputs leave flops
  assign prdata = rdata_reg;
  assign pready = 1'b1;
  assign pslverr = access_phase & ~addr_mapped;
  assign node_id_valid = node_valid_reg;
  assign root_holdoff = holdoff_reg;
  assign gap_count = gap_reg;
  assign long_reset_active = (lr_state_reg == sbpr_pkg::SBPR_LR_RUN);
  assign page_select = page_reg;
  assign port_select = port_reg;

  // ========================================================
  // Checks
  default clocking chk_cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // Helper counter: cycles spent in the current long reset
  logic [15:0] chk_len_reg;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      chk_len_reg <= 16'h0000;
    end else if (long_reset_active) begin
      chk_len_reg <= chk_len_reg + 16'h0001;
    end else begin
      chk_len_reg <= 16'h0000;
    end
  end

  // A read setup to a mapped word; its data shows one cycle later
  wire logic rd_setup = setup_phase & ~pwrite & addr_mapped;

  // Identity, root, cable power and request clear
  chk_root_clear: assert property (bus_reset_evt & ~root_won |=> !root_reg)
    else $error("root flag survived a bus-reset");
  chk_root_set: assert property (root_won |=> root_reg)
    else $error("root flag not set");
  chk_node_load: assert property (self_id_done |=>
    node_id_valid && node_id_reg == $past(self_id_node))
    else $error("node identifier not loaded");
  chk_node_clear: assert property (bus_reset_evt & ~self_id_done |=> !node_id_valid)
    else $error("node identifier still valid after bus-reset");
  chk_power_read: assert property (rd_setup && reg_idx == 4'h0 |=>
    prdata[0] == $past(cable_power_sense))
    else $error("cable power bit wrong");
  chk_lrr_clear: assert property (bus_reset_evt & ~lrr_set |=> !lrr_reg)
    else $error("long reset request not cleared");

  // Long reset request, hold-off and length
  chk_holdoff_keep: assert property (bus_reset_evt & ~wr_gap |=>
    root_holdoff == $past(root_holdoff))
    else $error("root holdoff changed by bus-reset");
  chk_wait_cancel: assert property (lr_state_reg == sbpr_pkg::SBPR_LR_WAIT &&
    !lrr_reg |=> !long_reset_active)
    else $error("withdrawn long reset still started");
  chk_lrr_start: assert property (lrr_set & ~link_op_busy & ~long_reset_active ##1
    !link_op_busy |=> long_reset_active)
    else $error("long reset did not start");
  chk_busy_wait: assert property (lr_state_reg == sbpr_pkg::SBPR_LR_WAIT &&
    link_op_busy |=> !long_reset_active)
    else $error("long reset began during traffic");
  chk_long_len: assert property ($fell(long_reset_active) |->
    $past(chk_len_reg) == 16'(LONG_RESET_CYCLES - 1))
    else $error("long reset length wrong");

  // Gap value
  chk_gap_write: assert property (wr_gap |=> gap_count == $past(pwdata[5:0]))
    else $error("gap write lost");
  chk_gap_reload: assert property (gap_reload |=> gap_count == 6'h3f)
    else $error("gap not reloaded");

  // Read views and ignored writes
  chk_rsvd_read: assert property (rd_setup && reg_idx >= 4'h4 && reg_idx <= 4'h6 |=>
    prdata == 32'h0000_0000)
    else $error("reserved base word not zero");
  chk_rdata_upper: assert property (rd_setup |=> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  chk_page_write: assert property (wr_page |=> page_select == $past(pwdata[7:5]) &&
    port_select == $past(pwdata[3:0]))
    else $error("page or port selector write lost");
  chk_paged_zero: assert property (rd_setup && reg_idx >= 4'h8 |=>
    prdata == 32'h0000_0000)
    else $error("paged read not zero");
  chk_fixed_ext: assert property (rd_setup && reg_idx == 4'h2 |=>
    prdata == 32'h0000_00e4)
    else $error("extended/port count wrong");
  chk_fixed_speed: assert property (rd_setup && reg_idx == 4'h3 |=>
    prdata == 32'h0000_0040)
    else $error("speed/delay wrong");
  chk_rsvd_write: assert property (wr_ok && reg_idx == 4'h6 |=>
    $stable(gap_reg) || $past(config_gap_load) || $past(bus_reset_evt))
    else $error("reserved write changed gap");
  chk_ro_node: assert property (wr_ok && reg_idx == 4'h0 && ~self_id_done |=>
    node_id_reg == $past(node_id_reg))
    else $error("write changed node identifier");

  // Scenarios worth seeing at least once
  cov_long_done: cover property (lr_done);
  cov_gap_reload: cover property (gap_reload);
  cov_busy_wait: cover property (lr_state_reg == sbpr_pkg::SBPR_LR_WAIT ##1
    long_reset_active);
  cov_root: cover property (root_won ##1 bus_reset_evt);
  cov_wait_cancel: cover property (lr_state_reg == sbpr_pkg::SBPR_LR_WAIT && !lrr_reg);

endmodule : sbpr_regs

`default_nettype wire

// ### sbpr_link_model.sv
// Link controller model: APB master that reaches the PHY register bank
`timescale 1ns/1ps
`default_nettype none

module sbpr_link_model (
  input wire logic core_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic hung
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    hung = 1'b0;
  end

  // ==========================================================
  // One transfer, request held until pready is sampled high
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) begin
      hung = 1'b1;
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data lines must not look like the last value
    pwdata <= ~wdata;
    #1;
  endtask : xfer
endmodule : sbpr_link_model
`default_nettype wire

// ### testbench.sv
// Self-checking bench of the serial bus PHY base register bank
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // Short long-reset so the run stays brief
  localparam int LR = 20;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
    logic err;
  } sbpr_row_type;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, hung, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [3:0] ev = 4'h0;
  logic [5:0] node = 6'h2a;
  logic [5:0] cfg_gap = 6'h0a;
  logic pwr_sense = 1'b1;
  logic busy = 1'b0;
  logic node_id_valid, root_holdoff, long_reset_active;
  logic [5:0] gap_count;
  logic [2:0] page_select;
  logic [3:0] port_select;
  int failures = 0;
  int checks_done = 0;
  int n;
  sbpr_row_type rows [16];

  always #2.5 core_clk = ~core_clk;

  sbpr_regs #(.LONG_RESET_CYCLES(LR)) u_dut (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_reset_in(ev[0]), .self_id_done(ev[1]), .self_id_node(node),
    .root_won(ev[2]), .cable_power_sense(pwr_sense), .config_gap_load(ev[3]),
    .config_gap_value(cfg_gap), .link_op_busy(busy), .node_id_valid(node_id_valid),
    .root_holdoff(root_holdoff), .gap_count(gap_count), .long_reset_active(long_reset_active),
    .page_select(page_select), .port_select(port_select));

  sbpr_link_model u_link (
    .core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hung(hung));

  // ==========================================================
  // Comparison, event pulse and closing report
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic pulse(input logic [3:0] m);
    @(posedge core_clk);
    ev <= m;
    @(posedge core_clk);
    ev <= 4'h0;
    #1;
  endtask : pulse

  task automatic finish_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // A bus that never answers ends the run at once
  always @(posedge hung) begin
    failures++;
    finish_test();
  end

  // Watchdog: a hang counts as a failure
  initial begin
    #50us;
    failures++;
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    rows = '{'{1'b0, 8'h08, 8'h00, 8'he4, 1'b0}, '{1'b0, 8'h0c, 8'h00, 8'h40, 1'b0},
             '{1'b1, 8'h0c, 8'hff, 8'h40, 1'b0}, '{1'b1, 8'h08, 8'hff, 8'he4, 1'b0},
             '{1'b1, 8'h00, 8'hff, 8'h01, 1'b0}, '{1'b0, 8'h04, 8'h00, 8'h3f, 1'b0},
             '{1'b1, 8'h04, 8'h95, 8'h95, 1'b0}, '{1'b1, 8'h1c, 8'hff, 8'hef, 1'b0},
             '{1'b1, 8'h10, 8'hff, 8'h00, 1'b0}, '{1'b1, 8'h14, 8'hff, 8'h00, 1'b0},
             '{1'b1, 8'h18, 8'hff, 8'h00, 1'b0}, '{1'b1, 8'h1c, 8'h6f, 8'h6f, 1'b0},
             '{1'b0, 8'h24, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h3c, 8'h00, 8'h00, 1'b0},
             '{1'b0, 8'h0c, 8'h00, 8'h40, 1'b0}, '{1'b1, 8'h40, 8'hff, 8'h00, 1'b1}};
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    check("gap", gap_count, 32'h3f);
    check("holdoff", root_holdoff, 32'h0);
    check("nodev", node_id_valid, 32'h0);
    check("ready", pready, 32'h1);
    $display("test reset values done");
    // Table rows: optional write, then read back
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        u_link.xfer(1'b1, {24'h0, rows[i].addr}, {24'h0, rows[i].wdata}, rd, err);
        check("wr_err", err, rows[i].err);
      end
      u_link.xfer(1'b0, {24'h0, rows[i].addr}, 32'h0, rd, err);
      check("rd_data", rd, {24'h0, rows[i].exp});
      check("rd_err", err, rows[i].err);
    end
    check("page", page_select, 32'h3);
    check("port", port_select, 32'hf);
    $display("test register table done");
    // Self-ID, root, cable power, bus-resets and gap reload
    pulse(4'h6);
    check("nodev", node_id_valid, 32'h1);
    u_link.xfer(1'b0, 32'h0, 32'h0, rd, err);
    check("reg0", rd, 32'hab);
    @(posedge core_clk);
    pwr_sense <= 1'b0;
    u_link.xfer(1'b0, 32'h0, 32'h0, rd, err);
    check("reg0", rd, 32'haa);
    pulse(4'h1);
    check("nodev", node_id_valid, 32'h0);
    check("gap", gap_count, 32'h15);
    check("holdoff", root_holdoff, 32'h1);
    u_link.xfer(1'b0, 32'h0, 32'h0, rd, err);
    check("root", rd[1:0], 32'h0);
    pulse(4'h1);
    check("gap", gap_count, 32'h3f);
    pulse(4'h8);
    pulse(4'h1);
    check("gap", gap_count, 32'h0a);
    $display("test bus-reset events done");
    // Long reset held off by a transfer in progress
    @(posedge core_clk);
    busy <= 1'b1;
    u_link.xfer(1'b1, 32'h4, 32'h4a, rd, err);
    repeat (5) @(posedge core_clk);
    #1;
    check("lr_held", long_reset_active, 32'h0);
    @(posedge core_clk);
    busy <= 1'b0;
    n = 0;
    while (long_reset_active !== 1'b1 && n < 10) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    n = 0;
    while (long_reset_active === 1'b1 && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("lr_len", n, LR);
    u_link.xfer(1'b0, 32'h4, 32'h0, rd, err);
    check("reg1", rd, 32'h0a);
    // A bus-reset while the request waits withdraws it
    @(posedge core_clk);
    busy <= 1'b1;
    u_link.xfer(1'b1, 32'h4, 32'h4a, rd, err);
    pulse(4'h1);
    busy <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    check("lr_cancel", long_reset_active, 32'h0);
    $display("test long reset done");
    // Hardware reset in mid-run clears holdoff and reloads gap
    u_link.xfer(1'b1, 32'h4, 32'h8a, rd, err);
    check("holdoff", root_holdoff, 32'h1);
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check("holdoff", root_holdoff, 32'h0);
    check("gap", gap_count, 32'h3f);
    @(posedge core_clk);
    resetn <= 1'b1;
    u_link.xfer(1'b0, 32'h4, 32'h0, rd, err);
    check("reg1", rd, 32'h3f);
    check("page", page_select, 32'h0);
    check("hung", hung, 32'h0);
    $display("test hardware reset done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
